// ===== rtl/bbd_classify.sv
`timescale 1ns/1ps
`include "bbd_map.svh"

module bbd_classify (
  input  wire logic [7:0]         i_opcode, // opcode byte
  output bbd_pkg::bbd_kind_t      o_kind,   // instruction class
  output logic [1:0]              o_len,    // length in bytes
  output logic [1:0]              o_cyc     // execution cycles
);
  import bbd_pkg::*;

  bbd_dec_t dec;

  // opcode table: class, byte count and cycle count
  always_comb begin
    dec = '{K_NONE, `BBD_LEN_1, `BBD_CYC_1};
    casez (i_opcode)
      `BBD_OP_NO_OPERATION:   dec = '{K_NO_OPERATION, `BBD_LEN_1, `BBD_CYC_1};
      `BBD_OP_CLEAR_C:        dec = '{K_CLEAR_C, `BBD_LEN_1, `BBD_CYC_1};
      `BBD_OP_SET_C:          dec = '{K_SET_C, `BBD_LEN_1, `BBD_CYC_1};
      `BBD_OP_INVERT_C:       dec = '{K_INVERT_C, `BBD_LEN_1, `BBD_CYC_1};
      `BBD_OP_CLEAR_BIT:      dec = '{K_CLEAR_BIT, `BBD_LEN_2, `BBD_CYC_1};
      `BBD_OP_SET_BIT:        dec = '{K_SET_BIT, `BBD_LEN_2, `BBD_CYC_1};
      `BBD_OP_INVERT_BIT:     dec = '{K_INVERT_BIT, `BBD_LEN_2, `BBD_CYC_1};
      `BBD_OP_AND_BIT:        dec = '{K_AND_BIT, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_AND_NBIT:       dec = '{K_AND_NBIT, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_OR_BIT:         dec = '{K_OR_BIT, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_OR_NBIT:        dec = '{K_OR_NBIT, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_CARRY_FROM_BIT: dec = '{K_C_FROM_BIT, `BBD_LEN_2, `BBD_CYC_1};
      `BBD_OP_BIT_FROM_CARRY: dec = '{K_BIT_FROM_C, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_PAT_PAGE_CALL:     dec = '{K_PAGE_CALL, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_PAT_PAGE_BRANCH:   dec = '{K_PAGE_BRANCH, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_FAR_CALL:       dec = '{K_FAR_CALL, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_OP_FAR_BRANCH:     dec = '{K_FAR_BRANCH, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_OP_SUB_RETURN:     dec = '{K_SUB_RETURN, `BBD_LEN_1, `BBD_CYC_2};
      `BBD_OP_INT_RETURN:     dec = '{K_INT_RETURN, `BBD_LEN_1, `BBD_CYC_2};
      `BBD_OP_NEAR_BRANCH:    dec = '{K_NEAR, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_POINTER_BRANCH: dec = '{K_POINTER, `BBD_LEN_1, `BBD_CYC_2};
      `BBD_OP_ACC_ZERO:       dec = '{K_ACC_ZERO, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_ACC_NONZERO:    dec = '{K_ACC_NONZERO, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_CARRY_SET:      dec = '{K_C_SET, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_CARRY_CLEAR:    dec = '{K_C_CLEAR, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_BIT_SET:        dec = '{K_BIT_SET, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_OP_BIT_CLEAR:      dec = '{K_BIT_CLEAR, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_OP_BIT_SET_CLEAR:  dec = '{K_BIT_SET_CLR, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_OP_CMP_DIR:        dec = '{K_CMP_DIR, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_OP_CMP_IMM:        dec = '{K_CMP_IMM, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_PAT_CMP_IND:       dec = '{K_CMP_IND, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_PAT_CMP_REG:       dec = '{K_CMP_REG, `BBD_LEN_3, `BBD_CYC_2};
      `BBD_PAT_DEC_REG:       dec = '{K_DEC_REG, `BBD_LEN_2, `BBD_CYC_2};
      `BBD_OP_DEC_DIR:        dec = '{K_DEC_DIR, `BBD_LEN_3, `BBD_CYC_2};
      default:                dec = '{K_NONE, `BBD_LEN_1, `BBD_CYC_1};
    endcase
  end

  // split the table entry into separate ports
  assign o_kind = dec.kind;
  assign o_len  = dec.len;
  assign o_cyc  = dec.cyc;

endmodule

// ===== rtl/bbd_core.sv
`timescale 1ns/1ps
`include "bbd_map.svh"

// Summary of operation
// - carry and/or with bit: two bytes, two cycles
// - bit to carry one cycle; carry to bit two
// - page call: low nibble 1, odd high nibble
// - page branch: low nibble 1, even high nibble
// - page target stays in next instruction's 2k page
// - far call/branch: three bytes, 16-bit target
// - near branch adds displacement to next address
// - pointer branch goes to accumulator plus pointer
// - branch on accumulator zero or nonzero
// - branch on carry set or clear
// - branch on addressed bit one or zero
// - branch on bit set, also clearing it
// - compare accumulator with direct/immediate, branch unequal
// - compare register or indirect with immediate
// - decrement operand, branch when result nonzero
// - displacement is signed byte from next instruction
// - low three opcode bits pick working register
// - opcode bit zero picks indirect pointer register
// - direct byte: low RAM or function register
// - 16-bit constant from bytes two and three
module bbd_core (
  input  wire logic        i_clk,          // machine-cycle clock
  input  wire logic        i_rstn,         // async reset, active low
  input  wire logic        i_fetch_valid,  // program byte present
  input  wire logic [7:0]  i_fetch_data,   // program byte
  output logic             o_fetch_req,    // byte wanted at o_fetch_addr
  output logic [15:0]      o_fetch_addr,   // program counter
  input  wire logic [7:0]  i_acc,          // accumulator
  input  wire logic        i_carry,        // carry flag
  input  wire logic [15:0] i_data_pointer, // data pointer
  input  wire logic        i_bit_val,      // value of bit at o_bit_addr
  input  wire logic [7:0]  i_direct_data,  // byte at o_direct_addr
  input  wire logic [7:0]  i_reg_data,     // working register o_reg_sel
  input  wire logic [7:0]  i_ind_data,     // RAM byte via pointer register
  input  wire logic [15:0] i_return_pc,    // address popped for returns
  output logic [7:0]       o_bit_addr,     // bit address operand
  output logic [7:0]       o_direct_addr,  // direct byte address
  output logic             o_direct_sfr,   // direct address is a function reg
  output logic [2:0]       o_reg_sel,      // working register index
  output logic             o_ind_sel,      // pointer register 0 or 1
  output logic             o_carry_we,     // carry write strobe
  output logic             o_carry_d,      // new carry
  output logic             o_bit_we,       // bit write strobe
  output logic             o_bit_d,        // new bit value
  output logic             o_reg_we,       // working register write strobe
  output logic [7:0]       o_reg_d,        // new register value
  output logic             o_direct_we,    // direct byte write strobe
  output logic [7:0]       o_direct_d,     // new direct byte
  output logic             o_call,         // push link address
  output logic [15:0]      o_call_link_pc, // link address to push
  output logic             o_return,       // pop return address
  output logic             o_int_return,   // return ends an interrupt
  output logic             o_retire,       // instruction finished
  output logic             o_unsupported   // opcode outside this group
);
  import bbd_pkg::*;
  bbd_state_t  state_q;
  bbd_kind_t   kind_q, kind_w;
  logic [1:0]  len_q, len_w, cyc_q, cyc_w, cnt_q;
  logic [7:0]  op_q, b2_q, b3_q, rel, cmp_a, cmp_b, dec_v, reg_d_q, direct_d_q;
  logic [15:0] pc_q, rel_tgt, tgt, link_q;
  logic        take, retire, taken;
  logic        carry_we_q, carry_d_q, bit_we_q, bit_d_q, reg_we_q, direct_we_q;
  logic        call_q, return_q, int_return_q, retire_q, unsup_q;
  // opcode table lookup on the incoming byte
  bbd_classify u_classify (
    .i_opcode (i_fetch_data),
    .o_kind   (kind_w),
    .o_len    (len_w),
    .o_cyc    (cyc_w)
  );

  // fetch handshake and retire point
  assign o_fetch_req  = (state_q != S_EXEC);
  assign o_fetch_addr = pc_q;
  assign take         = o_fetch_req && i_fetch_valid;
  assign retire       = (state_q == S_EXEC) && (cnt_q == cyc_q - 2'd1);

  // byte sequencer: opcode, operand bytes, then execution cycles
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= S_OPCODE;
    end else begin
      case (state_q)
        S_OPCODE: if (i_fetch_valid) begin
          state_q <= (len_w == `BBD_LEN_1) ? S_EXEC : S_BYTE2;
        end
        S_BYTE2: if (i_fetch_valid) begin
          state_q <= (len_q == `BBD_LEN_3) ? S_BYTE3 : S_EXEC;
        end
        S_BYTE3: if (i_fetch_valid) begin
          state_q <= S_EXEC;
        end
        S_EXEC: if (retire) begin
          state_q <= S_OPCODE;
        end
        default: state_q <= S_OPCODE;
      endcase
    end
  end

  // execution cycle counter
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= 2'd0;
    end else if (retire || state_q != S_EXEC) begin
      cnt_q <= 2'd0;
    end else begin
      cnt_q <= cnt_q + 2'd1;
    end
  end

  // instruction bytes held for the whole execution
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      op_q   <= 8'h00;
      kind_q <= K_NO_OPERATION;
      len_q  <= `BBD_LEN_1;
      cyc_q  <= `BBD_CYC_1;
      b2_q   <= 8'h00;
      b3_q   <= 8'h00;
    end else if (take) begin
      if (state_q == S_OPCODE) begin
        op_q   <= i_fetch_data;
        kind_q <= kind_w;
        len_q  <= len_w;
        cyc_q  <= cyc_w;
      end
      if (state_q == S_BYTE2) begin
        b2_q <= i_fetch_data;
      end
      if (state_q == S_BYTE3) begin
        b3_q <= i_fetch_data;
      end
    end
  end
  // operand addressing taken from the held bytes
  assign o_bit_addr    = b2_q;
  assign o_direct_addr = b2_q;
  assign o_direct_sfr  = b2_q[7];
  assign o_reg_sel     = op_q[2:0];
  assign o_ind_sel     = op_q[0];
  // displacement is the last byte; signed, from the next instruction
  assign rel     = (len_q == `BBD_LEN_3) ? b3_q : b2_q;
  assign rel_tgt = pc_q + {{8{rel[7]}}, rel};
  // branch condition, target and compare/decrement operands
  always_comb begin
    taken = 1'b0;
    tgt   = rel_tgt;
    cmp_a = i_acc;
    cmp_b = b2_q;
    dec_v = i_reg_data - 8'h01;
    case (kind_q)
      K_PAGE_CALL, K_PAGE_BRANCH: begin
        taken = 1'b1;
        tgt   = {pc_q[15:11], op_q[7:5], b2_q};
      end
      K_FAR_CALL, K_FAR_BRANCH: begin
        taken = 1'b1;
        tgt   = {b2_q, b3_q};
      end
      K_SUB_RETURN, K_INT_RETURN: begin
        taken = 1'b1;
        tgt   = i_return_pc;
      end
      K_NEAR: taken = 1'b1;
      K_POINTER: begin
        taken = 1'b1;
        tgt   = i_data_pointer + {8'h00, i_acc};
      end
      K_ACC_ZERO:    taken = (i_acc == 8'h00);
      K_ACC_NONZERO: taken = (i_acc != 8'h00);
      K_C_SET:       taken = i_carry;
      K_C_CLEAR:     taken = !i_carry;
      K_BIT_SET:     taken = i_bit_val;
      K_BIT_CLEAR:   taken = !i_bit_val;
      K_BIT_SET_CLR: taken = i_bit_val;
      K_CMP_DIR: begin
        cmp_b = i_direct_data;
        taken = (cmp_a != cmp_b);
      end
      K_CMP_IMM: taken = (cmp_a != cmp_b);
      K_CMP_IND: begin
        cmp_a = i_ind_data;
        taken = (cmp_a != cmp_b);
      end
      K_CMP_REG: begin
        cmp_a = i_reg_data;
        taken = (cmp_a != cmp_b);
      end
      K_DEC_REG: taken = (dec_v != 8'h00);
      K_DEC_DIR: begin
        dec_v = i_direct_data - 8'h01;
        taken = (dec_v != 8'h00);
      end
      default: taken = 1'b0;
    endcase
  end

  // program counter: bumps per byte, loads target on a taken retire
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pc_q <= 16'h0000;
    end else if (take) begin
      pc_q <= pc_q + 16'h0001;
    end else if (retire && taken) begin
      pc_q <= tgt;
    end
  end

  // carry and bit updates at retire
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      carry_we_q <= 1'b0;
      carry_d_q  <= 1'b0;
      bit_we_q   <= 1'b0;
      bit_d_q    <= 1'b0;
    end else begin
      carry_we_q <= 1'b0;
      bit_we_q   <= 1'b0;
      if (retire) begin
        case (kind_q)
          K_CLEAR_C, K_SET_C, K_INVERT_C: begin
            carry_we_q <= 1'b1;
            carry_d_q  <= (kind_q == K_INVERT_C) ? !i_carry : (kind_q == K_SET_C);
          end
          K_CLEAR_BIT, K_SET_BIT, K_INVERT_BIT: begin
            bit_we_q <= 1'b1;
            bit_d_q  <= (kind_q == K_INVERT_BIT) ? !i_bit_val : (kind_q == K_SET_BIT);
          end
          K_AND_BIT, K_AND_NBIT: begin
            carry_we_q <= 1'b1;
            carry_d_q  <= i_carry & (i_bit_val ^ (kind_q == K_AND_NBIT));
          end
          K_OR_BIT, K_OR_NBIT: begin
            carry_we_q <= 1'b1;
            carry_d_q  <= i_carry | (i_bit_val ^ (kind_q == K_OR_NBIT));
          end
          K_C_FROM_BIT: begin
            carry_we_q <= 1'b1;
            carry_d_q  <= i_bit_val;
          end
          K_BIT_FROM_C: begin
            bit_we_q <= 1'b1;
            bit_d_q  <= i_carry;
          end
          K_BIT_SET_CLR: begin
            bit_we_q <= i_bit_val;
            bit_d_q  <= 1'b0;
          end
          K_CMP_DIR, K_CMP_IMM, K_CMP_IND, K_CMP_REG: begin
            carry_we_q <= 1'b1;
            carry_d_q  <= (cmp_a < cmp_b); // borrow of the compare
          end
          default: carry_we_q <= 1'b0;
        endcase
      end
    end
  end

  // decrement write-back at retire
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      reg_we_q    <= 1'b0;
      reg_d_q     <= 8'h00;
      direct_we_q <= 1'b0;
      direct_d_q  <= 8'h00;
    end else begin
      reg_we_q    <= retire && (kind_q == K_DEC_REG);
      direct_we_q <= retire && (kind_q == K_DEC_DIR);
      if (retire) begin
        reg_d_q    <= dec_v;
        direct_d_q <= dec_v;
      end
    end
  end

  // call, return and retire strobes
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      call_q       <= 1'b0;
      link_q       <= 16'h0000;
      return_q     <= 1'b0;
      int_return_q <= 1'b0;
      retire_q     <= 1'b0;
      unsup_q      <= 1'b0;
    end else begin
      call_q       <= retire && (kind_q == K_PAGE_CALL || kind_q == K_FAR_CALL);
      return_q     <= retire && (kind_q == K_SUB_RETURN || kind_q == K_INT_RETURN);
      int_return_q <= retire && (kind_q == K_INT_RETURN);
      retire_q     <= retire;
      unsup_q      <= retire && (kind_q == K_NONE);
      if (retire) begin
        link_q <= pc_q;
      end
    end
  end

  assign o_carry_we     = carry_we_q;
  assign o_carry_d      = carry_d_q;
  assign o_bit_we       = bit_we_q;
  assign o_bit_d        = bit_d_q;
  assign o_reg_we       = reg_we_q;
  assign o_reg_d        = reg_d_q;
  assign o_direct_we    = direct_we_q;
  assign o_direct_d     = direct_d_q;
  assign o_call         = call_q;
  assign o_call_link_pc = link_q;
  assign o_return       = return_q;
  assign o_int_return   = int_return_q;
  assign o_retire       = retire_q;
  assign o_unsupported  = unsup_q;

  // checks on sequencing and results
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_exec_two;
    state_q == S_EXEC && cnt_q == 2'd0 && cyc_q == `BBD_CYC_2;
  endsequence
  sequence s_retire_late;
    !retire ##1 retire;
  endsequence
  a_two_cycle_exec: assert property (
    s_exec_two |-> s_retire_late
  ) else $error("two-cycle instruction retired at wrong cycle");
  a_one_cycle_exec: assert property (
    state_q == S_EXEC && cnt_q == 2'd0 && kind_q == K_C_FROM_BIT |-> retire
  ) else $error("bit to carry did not retire in one cycle");
  a_page_target: assert property (
    retire && kind_q == K_PAGE_BRANCH |=>
      o_fetch_addr == {$past(pc_q[15:11]), $past(op_q[7:5]), $past(b2_q)}
  ) else $error("page branch target wrong");
  a_call_link: assert property (
    retire && kind_q == K_PAGE_CALL |=> o_call && o_call_link_pc == $past(pc_q)
  ) else $error("page call link address wrong");
  a_far_target: assert property (
    retire && kind_q == K_FAR_BRANCH |=> o_fetch_addr == {$past(b2_q), $past(b3_q)}
  ) else $error("far branch target wrong");
  a_near_target: assert property (
    retire && kind_q == K_NEAR |=> o_fetch_addr == $past(rel_tgt) && o_fetch_req
  ) else $error("near branch target wrong");
  a_pointer_target: assert property (
    retire && kind_q == K_POINTER |=>
      o_fetch_addr == $past(i_data_pointer) + {8'h00, $past(i_acc)}
  ) else $error("pointer branch target wrong");
  a_acc_fallthru: assert property (
    retire && kind_q == K_ACC_ZERO && i_acc != 8'h00 |=> o_fetch_addr == $past(pc_q)
  ) else $error("zero test branched on nonzero accumulator");
  a_bit_cleared: assert property (
    retire && kind_q == K_BIT_SET_CLR && i_bit_val |=> o_bit_we && !o_bit_d
  ) else $error("tested bit not cleared");
  a_dec_writeback: assert property (
    retire && kind_q == K_DEC_REG |=> o_reg_we && o_reg_d == $past(i_reg_data) - 8'h01
  ) else $error("decrement write-back wrong");
  a_carry_and: assert property (
    retire && kind_q == K_AND_BIT |=>
      o_carry_we && o_carry_d == ($past(i_carry) & $past(i_bit_val))
  ) else $error("carry and result wrong");
endmodule

// ===== shared/bbd_map.svh
`ifndef BBD_MAP_SVH
`define BBD_MAP_SVH

// single-opcode encodings of the bit and control group
`define BBD_OP_NO_OPERATION     8'h00
`define BBD_OP_FAR_BRANCH       8'h02
`define BBD_OP_BIT_SET_CLEAR    8'h10
`define BBD_OP_FAR_CALL         8'h12
`define BBD_OP_BIT_SET          8'h20
`define BBD_OP_SUB_RETURN       8'h22
`define BBD_OP_BIT_CLEAR        8'h30
`define BBD_OP_INT_RETURN       8'h32
`define BBD_OP_CARRY_SET        8'h40
`define BBD_OP_CARRY_CLEAR      8'h50
`define BBD_OP_ACC_ZERO         8'h60
`define BBD_OP_ACC_NONZERO      8'h70
`define BBD_OP_OR_BIT           8'h72
`define BBD_OP_POINTER_BRANCH   8'h73
`define BBD_OP_NEAR_BRANCH      8'h80
`define BBD_OP_AND_BIT          8'h82
`define BBD_OP_BIT_FROM_CARRY   8'h92
`define BBD_OP_OR_NBIT          8'ha0
`define BBD_OP_CARRY_FROM_BIT   8'ha2
`define BBD_OP_AND_NBIT         8'hb0
`define BBD_OP_INVERT_BIT       8'hb2
`define BBD_OP_INVERT_C         8'hb3
`define BBD_OP_CMP_IMM          8'hb4
`define BBD_OP_CMP_DIR          8'hb5
`define BBD_OP_CLEAR_BIT        8'hc2
`define BBD_OP_CLEAR_C          8'hc3
`define BBD_OP_SET_BIT          8'hd2
`define BBD_OP_SET_C            8'hd3
`define BBD_OP_DEC_DIR          8'hd5

// opcode families (low nibble 1, working register, indirect pointer)
`define BBD_PAT_PAGE_BRANCH     8'b???0_0001
`define BBD_PAT_PAGE_CALL       8'b???1_0001
`define BBD_PAT_CMP_REG         8'b1011_1???
`define BBD_PAT_CMP_IND         8'b1011_011?
`define BBD_PAT_DEC_REG         8'b1101_1???

// instruction lengths in bytes and execution cycles
`define BBD_LEN_1               2'd1
`define BBD_LEN_2               2'd2
`define BBD_LEN_3               2'd3
`define BBD_CYC_1               2'd1
`define BBD_CYC_2               2'd2

`endif

// ===== shared/bbd_pkg.sv
package bbd_pkg;

  typedef enum logic [5:0] {
    K_NONE = 6'h00, K_NO_OPERATION = 6'h01, K_CLEAR_C = 6'h02, K_SET_C = 6'h03,
    K_INVERT_C = 6'h04, K_CLEAR_BIT = 6'h05, K_SET_BIT = 6'h06, K_INVERT_BIT = 6'h07,
    K_AND_BIT = 6'h08, K_AND_NBIT = 6'h09, K_OR_BIT = 6'h0a, K_OR_NBIT = 6'h0b,
    K_C_FROM_BIT = 6'h0c, K_BIT_FROM_C = 6'h0d, K_PAGE_CALL = 6'h0e,
    K_PAGE_BRANCH = 6'h0f, K_FAR_CALL = 6'h10, K_FAR_BRANCH = 6'h11,
    K_SUB_RETURN = 6'h12, K_INT_RETURN = 6'h13, K_NEAR = 6'h14, K_POINTER = 6'h15,
    K_ACC_ZERO = 6'h16, K_ACC_NONZERO = 6'h17, K_C_SET = 6'h18, K_C_CLEAR = 6'h19,
    K_BIT_SET = 6'h1a, K_BIT_CLEAR = 6'h1b, K_BIT_SET_CLR = 6'h1c, K_CMP_DIR = 6'h1d,
    K_CMP_IMM = 6'h1e, K_CMP_IND = 6'h1f, K_CMP_REG = 6'h20, K_DEC_REG = 6'h21,
    K_DEC_DIR = 6'h22
  } bbd_kind_t;

  typedef struct packed {
    bbd_kind_t   kind;
    logic [1:0]  len;
    logic [1:0]  cyc;
  } bbd_dec_t;

  typedef enum logic [1:0] {
    S_OPCODE = 2'b00, S_BYTE2 = 2'b01, S_BYTE3 = 2'b10, S_EXEC = 2'b11
  } bbd_state_t;

endpackage

// ===== sim/bbd_prog_mem.sv
`timescale 1ns/1ps
// program memory that answers every byte request, or every other one in slow mode
module bbd_prog_mem (
  input  wire logic        i_clk,   // clock
  input  wire logic        i_slow,  // stall every other cycle
  input  wire logic        i_req,   // byte wanted
  input  wire logic [15:0] i_addr,  // byte address
  output logic             o_valid, // byte present
  output logic [7:0]       o_data   // byte
);
  logic [7:0] mem_q [0:65535];
  logic       gap_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  // stall pattern and the last byte shown
  always_ff @(posedge i_clk) begin
    gap_q  <= i_slow & ~gap_q;
    last_q <= o_data;
  end
  // between answers the bus shows the inverse of the last byte
  assign o_valid = i_req & ~gap_q;
  assign o_data  = o_valid ? mem_q[i_addr] : ~last_q;
endmodule

// ===== sim/bit_and_branch_decoder_tb.sv
`timescale 1ns/1ps
module bit_and_branch_decoder_tb;
  import bbd_pkg::*;
  logic i_clk = 1'b0, i_rstn = 1'b0, slow = 1'b1, i_fetch_valid, i_carry = 1'b0, i_bit_val = 1'b0;
  logic [7:0] i_fetch_data, i_acc = 8'h00, i_direct_data = 8'h00, i_reg_data = 8'h00;
  logic [7:0] i_ind_data = 8'h00, o_bit_addr, o_direct_addr, o_reg_d, o_direct_d;
  logic [15:0] i_data_pointer = 16'h0000, i_return_pc = 16'h0000, o_fetch_addr, o_call_link_pc;
  logic o_fetch_req, o_direct_sfr, o_ind_sel, o_carry_we, o_carry_d, o_bit_we, o_bit_d, o_reg_we;
  logic o_direct_we, o_call, o_return, o_int_return, o_retire, o_unsupported;
  logic [2:0] o_reg_sel;
  int failures = 0, checks = 0;
  // clock, design and program memory
  always #5 i_clk = ~i_clk;
  bbd_core u_dut (.*);
  bbd_prog_mem u_mem (.i_clk(i_clk), .i_slow(slow), .i_req(o_fetch_req),
    .i_addr(o_fetch_addr), .o_valid(i_fetch_valid), .o_data(i_fetch_data));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ld2(input logic [15:0] a, input logic [15:0] b);
    {u_mem.mem_q[a], u_mem.mem_q[a + 16'h1]} = b;
  endtask
  task automatic ld3(input logic [15:0] a, input logic [23:0] b);
    {u_mem.mem_q[a], u_mem.mem_q[a + 16'h1], u_mem.mem_q[a + 16'h2]} = b;
  endtask
  // count edges up to the retire pulse, then check new pc and, when cyc is nonzero, the cycle count
  task automatic run(input logic [15:0] pc, input int cyc);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (o_retire !== 1'b1 && n < 20);
    chk(o_fetch_addr, pc);
    if (cyc > 0) chk(n[15:0], cyc[15:0]);
  endtask
  task automatic t_jumps;
    run(16'h07fe, 0);
    slow = 1'b0;
    ld2(16'h07fe, 16'h2140);
    run(16'h0940, 0);
    ld2(16'h0940, 16'h8080);
    run(16'h08c2, 4);
    $display("jumps done");
  endtask
  task automatic t_decrement;
    ld2(16'h08c2, 16'hd905);
    i_reg_data = 8'h01;
    run(16'h08c4, 4);
    chk(o_reg_we, 1'b1);
    chk(o_reg_d, 8'h00);
    chk(o_reg_sel, 3'h1);
    ld2(16'h08c4, 16'hdf7f);
    i_reg_data = 8'h02;
    run(16'h0945, 4);
    chk(o_reg_sel, 3'h7);
    $display("decrement done");
  endtask
  task automatic t_calls;
    ld2(16'h0945, 16'h5110);
    run(16'h0a10, 4);
    chk(o_call, 1'b1);
    chk(o_call_link_pc, 16'h0947);
    ld2(16'h0a10, 16'h7300);
    i_acc = 8'h10;
    i_data_pointer = 16'h1230;
    run(16'h1240, 3);
    ld2(16'h1240, 16'h2200);
    i_return_pc = 16'h0a20;
    run(16'h0a20, 3);
    chk(o_return, 1'b1);
    chk(o_int_return, 1'b0);
    $display("calls done");
  endtask
  task automatic t_cond;
    ld3(16'h0a20, 24'h400550);
    ld2(16'h0a23, 16'h05b6);
    run(16'h0a22, 4);
    run(16'h0a29, 4);
    ld3(16'h0a29, 24'hb63302);
    i_ind_data = 8'h33;
    run(16'h0a2c, 5);
    chk(o_ind_sel, 1'b0);
    ld3(16'h0a2c, 24'hb5a010);
    i_acc = 8'h20;
    i_direct_data = 8'h21;
    run(16'h0a3f, 5);
    chk(o_direct_addr, 8'ha0);
    chk(o_direct_sfr, 1'b1);
    ld3(16'h0a3f, 24'h102a04);
    i_bit_val = 1'b1;
    run(16'h0a46, 5);
    chk({o_bit_we, o_bit_d, o_bit_addr}, 16'h022a);
    $display("conditionals done");
  endtask
  task automatic t_carry;
    ld3(16'h0a46, 24'h822aa2);
    ld3(16'h0a49, 24'h2ac3a5);
    {i_carry, i_bit_val} = 2'b10;
    run(16'h0a48, 4);
    chk({o_carry_we, o_carry_d}, 2'b10);
    i_bit_val = 1'b1;
    run(16'h0a4a, 3);
    chk({o_carry_we, o_carry_d}, 2'b11);
    run(16'h0a4b, 2);
    chk({o_carry_we, o_carry_d}, 2'b10);
    run(16'h0a4c, 2);
    chk(o_unsupported, 1'b1);
    ld2(16'h0a4c, 16'h6080);
    i_acc = 8'h00;
    run(16'h09ce, 4);
    $display("carry done");
  endtask
  // carry and bit set, invert, transfer and or/and forms, then no-operation
  task automatic t_bitops;
    ld3(16'h09ce, 24'hd3b3c2);
    ld3(16'h09d1, 24'h2ad22a);
    ld3(16'h09d4, 24'hb22a92);
    ld3(16'h09d7, 24'h2a722a);
    ld3(16'h09da, 24'ha02ab0);
    ld3(16'h09dd, 24'h2a0070);
    {i_carry, i_bit_val} = 2'b01;
    run(16'h09cf, 2);
    chk({o_carry_we, o_carry_d}, 2'b11);
    i_carry = 1'b1;
    run(16'h09d0, 2);
    chk({o_carry_we, o_carry_d}, 2'b10);
    run(16'h09d2, 3);
    chk({o_bit_we, o_bit_d}, 2'b10);
    i_bit_val = 1'b0;
    run(16'h09d4, 3);
    chk({o_bit_we, o_bit_d}, 2'b11);
    run(16'h09d6, 3);
    chk({o_bit_we, o_bit_d}, 2'b11);
    run(16'h09d8, 4);
    chk({o_bit_we, o_bit_d}, 2'b11);
    {i_carry, i_bit_val} = 2'b01;
    run(16'h09da, 4);
    chk({o_carry_we, o_carry_d}, 2'b11);
    run(16'h09dc, 4);
    chk({o_carry_we, o_carry_d}, 2'b10);
    {i_carry, i_bit_val} = 2'b10;
    run(16'h09de, 4);
    chk({o_carry_we, o_carry_d}, 2'b11);
    run(16'h09df, 2);
    chk({o_carry_we, o_bit_we, o_call, o_return, o_unsupported}, 5'h00);
    chk(o_fetch_req, 1'b1);
    $display("bit operations done");
  endtask
  // remaining tests, compares, direct decrement, far call, interrupt return
  task automatic t_flow;
    ld3(16'h09e0, 24'h056010);
    ld3(16'h09e3, 24'h202a03);
    ld3(16'h09e6, 24'h302a03);
    ld3(16'h09ec, 24'hb40105);
    ld3(16'h09ef, 24'hbd4402);
    ld3(16'h09f4, 24'hd54510);
    ld3(16'h09f7, 24'h121234);
    ld2(16'h1234, 16'h3200);
    i_acc = 8'h00;
    run(16'h09e1, 4);
    i_acc = 8'h01;
    run(16'h09e3, 4);
    i_bit_val = 1'b0;
    run(16'h09e6, 5);
    run(16'h09ec, 5);
    run(16'h09ef, 5);
    i_reg_data = 8'h45;
    run(16'h09f4, 5);
    chk(o_reg_sel, 3'h5);
    i_direct_data = 8'h01;
    run(16'h09f7, 5);
    chk({o_direct_we, o_direct_d}, 9'h100);
    chk(o_direct_sfr, 1'b0);
    run(16'h1234, 5);
    chk(o_call, 1'b1);
    chk(o_call_link_pc, 16'h09fa);
    i_return_pc = 16'h09fa;
    run(16'h09fa, 3);
    chk({o_return, o_int_return}, 2'b11);
    $display("flow control done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence: reset for 20 cycles, then the program chain
  initial begin
    ld3(16'h0000, 24'h0207fe);
    repeat (20) @(posedge i_clk);
    #1 i_rstn = 1'b1;
    t_jumps();
    t_decrement();
    t_calls();
    t_cond();
    t_carry();
    t_bitops();
    t_flow();
    tally_and_finish();
  end
  // watchdog well beyond the expected run
  initial begin
    #20000;
    failures++;
    tally_and_finish();
  end
endmodule
